// >>> rtl/irq_bank.sv
// Interrupt mask and factor flag bank with request output
// Notes on behaviour
// RL1: Stopwatch mask: run, lap, 1Hz, 10Hz enables
// RL2: Converter mask: reference bit1, sensor bit0
// RL3: Clock-timer mask bit0 enables 32Hz, resets zero
// RL4: Compare-match flags, write one clears
// RL5: Underflow flags timers 2..0, write one clears
// RL6: Serial flag bit0, write one clears
// RL7: Key group A flag bit0, write one clears
// RL8: Key group B flag bit0, write one clears
// RL9: Clock-timer flags 1,2,8,32Hz, write one clears
// RL10: Stopwatch flags run, lap, 1Hz, 10Hz
// RL11: Converter flags reference and sensor, write-one clear
// RL12: Unused bits read zero, ignore writes
// RL13: Reset clears all masks and flags
// RL14: Flags set regardless of mask state
// RL15: Interrupts blocked until both stack pointers loaded
// RL16: Service routine clears flag before re-enabling
// RL17: Request while any flag and mask both set; here only the stopwatch, converter and clock-timer pairs raise irq_o
`timescale 1ns/1ps
module irq_bank
(
   // Clock and reset
   input  wire logic                 ref_clk_i,
   input  wire logic                 reset_i,
   // Register port
   input  wire logic [15:0]          addr_i,
   input  wire logic [3:0]           wdata_i,
   input  wire logic                 wr_i,
   input  wire logic                 rd_i,
   output logic      [3:0]           rdata_o,
   // Event pulses from peripherals, one bit per flag position
   input  wire irq_bank_pkg::flags_t event_i,
   // Stack pointer load strobes from the core
   input  wire logic                 wide_sp_load_i,
   input  wire logic                 nibble_sp_load_i,
   // Request to the core
   output logic                      irq_o,
   output logic                      nmi_allow_o
);
   irq_bank_pkg::state_t st_reg;
   irq_bank_pkg::state_t st_next;
   irq_bank_pkg::flags_t f_bits;
   logic                 pend;

   // Implemented flag bits, one field per source's flag register
   assign f_bits = '{cmp: irq_bank_pkg::CMP_BITS,
                     uf: irq_bank_pkg::UF_BITS,
                     ser: irq_bank_pkg::ONE_BIT,
                     key_a: irq_bank_pkg::ONE_BIT,
                     key_b: irq_bank_pkg::ONE_BIT,
                     ct: irq_bank_pkg::CT_FLAG_BITS,
                     sw: irq_bank_pkg::SW_BITS,
                     conv: irq_bank_pkg::CONV_BITS};

   // Only the masks held here gate; other sources' masks live elsewhere
   assign pend = |(st_reg.flags.sw & st_reg.masks.sw)
               | |(st_reg.flags.conv & st_reg.masks.conv)
               | |(st_reg.flags.ct & st_reg.masks.ct); // RL17
   assign nmi_allow_o = st_reg.wide_sp_set & st_reg.nibble_sp_set; // RL15
   assign irq_o = pend & nmi_allow_o; // RL15
   assign rdata_o = st_reg.rdata;

   function automatic logic [3:0] w1c(input logic [3:0] cur,
                                      input logic [3:0] ev,
                                      input logic [3:0] bits,
                                      input logic       hit,
                                      input logic [3:0] wd);
      logic [3:0] clr;
      clr = hit ? wd : 4'h0;
      // Set wins over a simultaneous clear so no event is lost
      w1c = ((cur & ~clr) | ev) & bits; // RL14 RL12
   endfunction

   always_comb
   begin
      logic wr_sp;
      wr_sp = 1'b0;
      st_next = st_reg;
      st_next.rdata = 4'h0;
      st_next.flags.cmp = w1c(st_reg.flags.cmp, event_i.cmp, f_bits.cmp,
         wr_i && addr_i == irq_bank_pkg::CMP_FLAG_ADDR, wdata_i); // RL4
      st_next.flags.uf = w1c(st_reg.flags.uf, event_i.uf, f_bits.uf,
         wr_i && addr_i == irq_bank_pkg::UF_FLAG_ADDR, wdata_i); // RL5
      st_next.flags.ser = w1c(st_reg.flags.ser, event_i.ser, f_bits.ser,
         wr_i && addr_i == irq_bank_pkg::SER_FLAG_ADDR, wdata_i); // RL6
      st_next.flags.key_a = w1c(st_reg.flags.key_a, event_i.key_a,
         f_bits.key_a, wr_i && addr_i == irq_bank_pkg::KA_FLAG_ADDR,
         wdata_i); // RL7
      st_next.flags.key_b = w1c(st_reg.flags.key_b, event_i.key_b,
         f_bits.key_b, wr_i && addr_i == irq_bank_pkg::KB_FLAG_ADDR,
         wdata_i); // RL8
      st_next.flags.ct = w1c(st_reg.flags.ct, event_i.ct, f_bits.ct,
         wr_i && addr_i == irq_bank_pkg::CT_FLAG_ADDR, wdata_i); // RL9
      st_next.flags.sw = w1c(st_reg.flags.sw, event_i.sw, f_bits.sw,
         wr_i && addr_i == irq_bank_pkg::SW_FLAG_ADDR, wdata_i); // RL10
      st_next.flags.conv = w1c(st_reg.flags.conv, event_i.conv,
         f_bits.conv, wr_i && addr_i == irq_bank_pkg::CONV_FLAG_ADDR,
         wdata_i); // RL11
      if (wr_i && addr_i == irq_bank_pkg::SW_MASK_ADDR)
      begin
         st_next.masks.sw = wdata_i & irq_bank_pkg::SW_BITS; // RL1
      end
      else if (wr_i && addr_i == irq_bank_pkg::CONV_MASK_ADDR)
      begin
         st_next.masks.conv = wdata_i & irq_bank_pkg::CONV_BITS; // RL2 RL12
      end
      else if (wr_i && addr_i == irq_bank_pkg::CT_MASK_ADDR)
      begin
         st_next.masks.ct = wdata_i & irq_bank_pkg::CT_MASK_BITS; // RL3
      end
      // Loading one pointer blocks until the other follows
      wr_sp = wide_sp_load_i | nibble_sp_load_i;
      if (wr_sp)
      begin
         st_next.wide_sp_set = wide_sp_load_i |
            (st_reg.wide_sp_set & ~st_reg.nibble_sp_set); // RL15
         st_next.nibble_sp_set = nibble_sp_load_i |
            (st_reg.nibble_sp_set & ~st_reg.wide_sp_set); // RL15
      end
      // Read data; unmapped addresses read zero
      if (rd_i)
      begin
         if (addr_i == irq_bank_pkg::SW_MASK_ADDR)
            st_next.rdata = st_reg.masks.sw;
         else if (addr_i == irq_bank_pkg::CONV_MASK_ADDR)
            st_next.rdata = st_reg.masks.conv;
         else if (addr_i == irq_bank_pkg::CT_MASK_ADDR)
            st_next.rdata = st_reg.masks.ct;
         else if (addr_i == irq_bank_pkg::CMP_FLAG_ADDR)
            st_next.rdata = st_reg.flags.cmp;
         else if (addr_i == irq_bank_pkg::UF_FLAG_ADDR)
            st_next.rdata = st_reg.flags.uf;
         else if (addr_i == irq_bank_pkg::SER_FLAG_ADDR)
            st_next.rdata = st_reg.flags.ser;
         else if (addr_i == irq_bank_pkg::KA_FLAG_ADDR)
            st_next.rdata = st_reg.flags.key_a;
         else if (addr_i == irq_bank_pkg::KB_FLAG_ADDR)
            st_next.rdata = st_reg.flags.key_b;
         else if (addr_i == irq_bank_pkg::CT_FLAG_ADDR)
            st_next.rdata = st_reg.flags.ct;
         else if (addr_i == irq_bank_pkg::SW_FLAG_ADDR)
            st_next.rdata = st_reg.flags.sw;
         else if (addr_i == irq_bank_pkg::CONV_FLAG_ADDR)
            st_next.rdata = st_reg.flags.conv;
      end
   end

   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         st_reg <= '0; // RL13
      end
      else
      begin
         st_reg <= st_next;
      end
   end
endmodule

// >>> rtl/irq_bank_pkg.sv
// Register map, field layouts and reset values of the interrupt bank
package irq_bank_pkg;
   localparam int          ADDR_W          = 16;
   localparam int          DATA_W          = 4;
   localparam logic [15:0] SW_MASK_ADDR    = 16'hffe6;
   localparam logic [15:0] CONV_MASK_ADDR  = 16'hffe7;
   localparam logic [15:0] CT_MASK_ADDR    = 16'hffe5;
   localparam logic [15:0] CMP_FLAG_ADDR   = 16'hfff0;
   localparam logic [15:0] UF_FLAG_ADDR    = 16'hfff1;
   localparam logic [15:0] SER_FLAG_ADDR   = 16'hfff2;
   localparam logic [15:0] KA_FLAG_ADDR    = 16'hfff3;
   localparam logic [15:0] KB_FLAG_ADDR    = 16'hfff4;
   localparam logic [15:0] CT_FLAG_ADDR    = 16'hfff5;
   localparam logic [15:0] SW_FLAG_ADDR    = 16'hfff6;
   localparam logic [15:0] CONV_FLAG_ADDR  = 16'hfff7;
   localparam logic [3:0]  MASK_RESET      = 4'h0;
   localparam logic [3:0]  FLAG_RESET      = 4'h0;
   // Implemented bits per register; the rest read zero
   localparam logic [3:0]  SW_BITS         = 4'hf;
   localparam logic [3:0]  CONV_BITS       = 4'h3;
   localparam logic [3:0]  CT_MASK_BITS    = 4'h1;
   localparam logic [3:0]  CMP_BITS        = 4'h3;
   localparam logic [3:0]  UF_BITS         = 4'h7;
   localparam logic [3:0]  ONE_BIT         = 4'h1;
   localparam logic [3:0]  CT_FLAG_BITS    = 4'hf;

   typedef struct packed {
      logic [3:0] cmp;
      logic [3:0] uf;
      logic [3:0] ser;
      logic [3:0] key_a;
      logic [3:0] key_b;
      logic [3:0] ct;
      logic [3:0] sw;
      logic [3:0] conv;
   } flags_t;

   typedef struct packed {
      logic [3:0] sw;
      logic [3:0] conv;
      logic [3:0] ct;
   } masks_t;

   typedef struct packed {
      flags_t     flags;
      masks_t     masks;
      logic       wide_sp_set;
      logic       nibble_sp_set;
      logic [3:0] rdata;
   } state_t;
endpackage

// >>> test/irq_bank_chk.sv
// Concurrent checks on the interrupt bank ports
`timescale 1ns/1ps
module irq_bank_chk
(
   // Clock, reset and register port
   input wire logic                 ref_clk_i,
   input wire logic                 reset_i,
   input wire logic [15:0]          addr_i,
   input wire logic                 wr_i,
   input wire logic                 rd_i,
   input wire logic [3:0]           rdata_o,
   // Events, pointer loads and requests
   input wire irq_bank_pkg::flags_t event_i,
   input wire logic                 wide_sp_load_i,
   input wire logic                 nibble_sp_load_i,
   input wire logic                 irq_o,
   input wire logic                 nmi_allow_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   a_rd_idle: assert property (!$past(rd_i) |-> rdata_o == 4'h0)
      else $error("read data not zero outside read");
   a_sp_gate: assert property (irq_o |-> nmi_allow_o)
      else $error("request before both pointers loaded");
   a_nmi_cause: assert property ($rose(nmi_allow_o) |->
      $past(wide_sp_load_i) || $past(nibble_sp_load_i))
      else $error("unblock without pointer load");
   a_nmi_keep: assert property (nmi_allow_o && !wide_sp_load_i
      && !nibble_sp_load_i |=> nmi_allow_o)
      else $error("unblock lost without pointer load");
   a_irq_fall: assert property ($fell(irq_o) |->
      $past(wr_i) || $fell(nmi_allow_o))
      else $error("request dropped without cause");
   a_irq_rise: assert property ($rose(irq_o) |->
      $past(wr_i || (|event_i)) || $rose(nmi_allow_o))
      else $error("request raised without cause");
   a_cmp_unused: assert property ($past(rd_i &&
      addr_i == irq_bank_pkg::CMP_FLAG_ADDR) |-> rdata_o[3:2] == 2'b00)
      else $error("unused compare flag bits not zero");
   a_ser_unused: assert property ($past(rd_i &&
      addr_i == irq_bank_pkg::SER_FLAG_ADDR) |-> rdata_o[3:1] == 3'b000)
      else $error("unused serial flag bits not zero");
endmodule
bind irq_bank irq_bank_chk irq_bank_chk_inst (.ref_clk_i(ref_clk_i),
   .reset_i(reset_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
   .rdata_o(rdata_o), .event_i(event_i), .wide_sp_load_i(wide_sp_load_i),
   .nibble_sp_load_i(nibble_sp_load_i), .irq_o(irq_o),
   .nmi_allow_o(nmi_allow_o));

// >>> test/irq_bank_tb_top.sv
// Register-level testbench of the interrupt bank
`timescale 1ns/1ps
module irq_bank_tb_top;
   logic                 ref_clk_i = 1'b0;
   logic                 reset_i = 1'b1;
   logic [15:0]          addr_i = '0;
   logic [3:0]           wdata_i = '0;
   logic                 wr_i = 1'b0;
   logic                 rd_i = 1'b0;
   logic [3:0]           rdata_o;
   irq_bank_pkg::flags_t event_i;
   logic                 wide;
   logic                 nibble;
   logic                 irq_o;
   logic                 nmi_allow_o;
   int                   err_total = 0;
   int                   cmp_count = 0;
   int                   cyc = 0;
   logic [3:0]           fb[8] = '{4'h3, 4'h7, 4'h1, 4'h1, 4'h1, 4'hf,
                                   4'hf, 4'h3};
   logic [3:0]           mb[3] = '{4'h1, 4'hf, 4'h3};
   always #5 ref_clk_i = ~ref_clk_i;
   irq_bank irq_bank_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .event_i(event_i), .wide_sp_load_i(wide),
      .nibble_sp_load_i(nibble), .irq_o(irq_o), .nmi_allow_o(nmi_allow_o));
   irq_src irq_src_inst (.ref_clk_i(ref_clk_i), .event_o(event_i),
      .wide_o(wide), .nibble_o(nibble));
   task automatic chk(input logic [3:0] s, input logic [3:0] e);
      cmp_count++;
      if (s !== e)
      begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [3:0] d);
      @(posedge ref_clk_i);
      {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [15:0] a, input logic [3:0] e);
      @(posedge ref_clk_i);
      {addr_i, rd_i} <= {a, 1'b1};
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o, e);
   endtask
   task automatic print_verdict;
      $display("mismatches %0d compares %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Whole run needs well under a thousand cycles
   always @(posedge ref_clk_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_total++;
         print_verdict;
      end
   end
   initial
   begin
      repeat (5) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      for (int i = 0; i < 8; i++) rd(16'hfff0 + 16'(i), 4'h0);
      for (int i = 0; i < 3; i++) rd(16'hffe5 + 16'(i), 4'h0);
      irq_src_inst.fire('1, 1'b0, 1'b0);
      for (int i = 0; i < 8; i++)
      begin
         rd(16'hfff0 + 16'(i), fb[i]);
         wr(16'hfff0 + 16'(i), 4'h0);
         rd(16'hfff0 + 16'(i), fb[i]);
      end
      for (int i = 0; i < 3; i++)
      begin
         wr(16'hffe5 + 16'(i), 4'hf);
         rd(16'hffe5 + 16'(i), mb[i]);
      end
      wr(16'h0000, 4'hf);
      rd(16'h0000, 4'h0);
      chk({2'b00, irq_o, nmi_allow_o}, 4'h0);
      irq_src_inst.fire('0, 1'b1, 1'b0);
      #1 chk({2'b00, irq_o, nmi_allow_o}, 4'h0);
      irq_src_inst.fire('0, 1'b0, 1'b1);
      #1 chk({2'b00, irq_o, nmi_allow_o}, 4'h3);
      irq_src_inst.fire('0, 1'b1, 1'b0);
      #1 chk({2'b00, irq_o, nmi_allow_o}, 4'h0);
      irq_src_inst.fire('0, 1'b0, 1'b1);
      wr(16'hfff6, 4'h5);
      rd(16'hfff6, 4'ha);
      for (int i = 0; i < 8; i++)
      begin
         wr(16'hfff0 + 16'(i), 4'hf);
         rd(16'hfff0 + 16'(i), 4'h0);
      end
      chk({2'b00, irq_o, nmi_allow_o}, 4'h1);
      // Upper clock-timer flags have no mask here, so no request
      irq_src_inst.fire(irq_bank_pkg::flags_t'(32'h0000_0e00), 1'b0, 1'b0);
      #1 chk({2'b00, irq_o, nmi_allow_o}, 4'h1);
      // Event and write-one clear in one cycle: the event must survive
      fork
         irq_src_inst.fire(irq_bank_pkg::flags_t'(32'h0000_0100), 1'b0,
            1'b0);
         wr(16'hfff5, 4'hf);
      join
      chk({2'b00, irq_o, nmi_allow_o}, 4'h3);
      rd(16'hfff5, 4'h1);
      wr(16'hfff5, 4'h1);
      chk({2'b00, irq_o, nmi_allow_o}, 4'h1);
      wr(16'hffe6, 4'h0);
      irq_src_inst.fire(irq_bank_pkg::flags_t'(32'h0000_00f0), 1'b0, 1'b0);
      #1 chk({2'b00, irq_o, nmi_allow_o}, 4'h1);
      wr(16'hffe6, 4'h8);
      chk({2'b00, irq_o, nmi_allow_o}, 4'h3);
      // Reset in mid-run must drop flags, masks and pointer state
      @(posedge ref_clk_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      #1 chk({2'b00, irq_o, nmi_allow_o}, 4'h0);
      rd(16'hfff6, 4'h0);
      rd(16'hffe6, 4'h0);
      print_verdict;
   end
endmodule

// >>> test/irq_src.sv
// Peripheral event and stack pointer load source
`timescale 1ns/1ps
module irq_src
(
   // Clock
   input  wire logic           ref_clk_i,
   // Pulses toward the bank
   output irq_bank_pkg::flags_t event_o,
   output logic                wide_o,
   output logic                nibble_o
);
   initial {event_o, wide_o, nibble_o} = '0;
   // One-cycle pulses only; a held level would mask write-one clears
   task automatic fire(input irq_bank_pkg::flags_t ev, input logic w,
                       input logic n);
      @(posedge ref_clk_i);
      {event_o, wide_o, nibble_o} <= {ev, w, n};
      @(posedge ref_clk_i);
      {event_o, wide_o, nibble_o} <= '0;
   endtask
endmodule
